// ==== verilog/trw_top.sv ====
// Table read/write unit: executes table read and table write instructions.
// Assumes the decoder offers an opcode only while busy is low, and that
// program memory returns pm_rdata in the same cycle that pm_rd is high.
//
// Contract
// - Read opcode ends 10 plus mode; 0 none,1 post-inc,2 post-dec,3 pre-inc
// - Pointer is a 21-bit byte address spanning 2 Mbytes
// - Pointer bit 0 picks low (0) or high (1) byte of the word
// - Read loads addressed memory byte into latch, adjusting pointer per mode
// - Write copies latch into holding register chosen by pointer low 3 bits
// - Write opcode ends 11 plus mode, same mode values as reads
// - Write loads only holding register, never touches program memory
`timescale 1ns/1ps
module trw_top
  import trw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Instruction port
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_opcode,
  output logic             busy,
  output logic             done,
  // Program memory read port
  output logic             pm_rd,
  output logic [19:0]      pm_addr,
  input  wire logic [15:0] pm_rdata,
  // Holding registers toward the flash programmer
  output logic [63:0]      hold_data,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);
  import trw_pkg::*;

  typedef struct packed {
    trw_st_t     st;
    logic        is_write;
    trw_mode_t   mode;
    logic [20:0] ptr;
    logic [20:0] eff;
    logic [7:0]  latch;
    logic        pm_rd;
    logic [19:0] pm_addr;
    logic        busy;
    logic        done;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } trw_state_t;

  trw_state_t  s;
  trw_state_t  next_s;

  logic        is_rd_op;
  logic        is_wr_op;
  logic        accept;
  logic [20:0] ptr_inc;
  logic [20:0] ptr_dec;
  logic [7:0]  byte_sel;
  logic        hold_we;
  logic        apb_setup;
  logic        apb_write;
  logic [7:0]  hold_byte;

  // ---------------------------------------------------------------
  // Decode and datapath helpers
  // ---------------------------------------------------------------
  // Opcode match on the upper 14 bits
  assign is_rd_op  = instr_opcode[15:2] == OP_READ;
  assign is_wr_op  = instr_opcode[15:2] == OP_WRITE;
  assign accept    = instr_valid && s.st == ST_IDLE && (is_rd_op || is_wr_op);
  // Pointer arithmetic wraps inside the 21-bit space
  assign ptr_inc   = s.ptr + 21'h000001;
  assign ptr_dec   = s.ptr - 21'h000001;
  // Byte lane select within the fetched word
  assign byte_sel  = s.eff[0] ? pm_rdata[15:8] : pm_rdata[7:0];
  // Holding register written only in the completing cycle of a write
  assign hold_we   = s.st == ST_COMPLETE && s.is_write;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && s.pready && pwrite;
  assign hold_byte = hold_data[{paddr[4:2], 3'b000} +: 8];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    unique case (s.st)
      ST_IDLE: begin
        if (accept) begin
          next_s.st       = ST_ACCESS;
          next_s.busy     = 1'b1;
          next_s.is_write = is_wr_op;
          next_s.mode     = trw_mode_t'(instr_opcode[1:0]);
          // Pre-increment moves the pointer before the access
          if (trw_mode_t'(instr_opcode[1:0]) == MODE_PRE_INC) begin
            next_s.ptr = ptr_inc;
            next_s.eff = ptr_inc;
          end else begin
            next_s.eff = s.ptr;
          end
        end
      end
      ST_ACCESS: begin
        // Memory request only for reads
        next_s.st      = ST_COMPLETE;
        next_s.pm_rd   = !s.is_write;
        next_s.pm_addr = s.eff[20:1];
      end
      ST_COMPLETE: begin
        next_s.st    = ST_IDLE;
        next_s.pm_rd = 1'b0;
        next_s.busy  = 1'b0;
        next_s.done  = 1'b1;
        if (!s.is_write) begin
          next_s.latch = byte_sel;
        end
        // Post adjustment after the transfer
        unique case (s.mode)
          MODE_POST_INC: next_s.ptr = ptr_inc;
          MODE_POST_DEC: next_s.ptr = ptr_dec;
          MODE_NONE,
          MODE_PRE_INC:  next_s.ptr = s.ptr;
        endcase
      end
      default: begin
        next_s.st    = ST_IDLE;
        next_s.busy  = 1'b0;
        next_s.pm_rd = 1'b0;
      end
    endcase

    // APB: answer registered in setup, one-cycle access phase
    next_s.pready = apb_setup;
    if (apb_setup) begin
      next_s.prdata  = 32'h00000000;
      next_s.pslverr = 1'b0;
      if (paddr == ADDR_PTR) begin
        next_s.prdata  = {11'h000, s.ptr};
        next_s.pslverr = pwrite && s.busy;
      end else if (paddr == ADDR_LATCH) begin
        next_s.prdata  = {24'h000000, s.latch};
        next_s.pslverr = pwrite && s.busy;
      end else if (paddr == ADDR_STATUS) begin
        next_s.prdata  = {31'h00000000, s.busy};
        next_s.pslverr = pwrite;
      end else if (paddr[7:5] == ADDR_HOLD[7:5] && paddr[1:0] == 2'b00) begin
        next_s.prdata  = {24'h000000, hold_byte};
        next_s.pslverr = pwrite;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    // Software writes land only when accepted without error
    if (apb_write && !s.pslverr) begin
      if (paddr == ADDR_PTR) begin
        next_s.ptr = pwdata[20:0];
      end else if (paddr == ADDR_LATCH) begin
        next_s.latch = pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: ST_IDLE, is_write: 1'b0, mode: MODE_NONE, ptr: RST_PTR,
             eff: RST_PTR, latch: RST_LATCH, pm_rd: 1'b0, pm_addr: 20'h00000,
             busy: 1'b0, done: 1'b0, pready: 1'b0, pslverr: 1'b0,
             prdata: 32'h00000000};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Holding registers
  // ---------------------------------------------------------------
  trw_hold_regs #(
    .N (HOLD_N)
  ) u_hold (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (hold_we),
    .wr_idx    (s.eff[2:0]),
    .wr_data   (s.latch),
    .hold_data (hold_data)
  );

  // Outputs straight from state flops
  assign busy    = s.busy;
  assign done    = s.done;
  assign pm_rd   = s.pm_rd;
  assign pm_addr = s.pm_addr;
  assign pready  = s.pready;
  assign prdata  = s.prdata;
  assign pslverr = s.pslverr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Sequences of an instruction's execute cycles
  // ---------------------------------------------------------------
  sequence s_acc_rd;
    accept && is_rd_op;
  endsequence
  sequence s_acc_wr;
    accept && is_wr_op;
  endsequence
  sequence s_acc_rd_plain;
    accept && is_rd_op && instr_opcode[1:0] != 2'b11;
  endsequence
  // Strobe only in the second execute cycle, at the unmoved pointer
  sequence s_rd_steps;
    !pm_rd ##1 (pm_rd && pm_addr == $past(s.ptr[20:1], 2)) ##1 !pm_rd;
  endsequence
  sequence s_done_seq;
    busy[*2] ##1 (!busy && done);
  endsequence

  // Pre-increment moves the pointer first, then reads the new word
  a_pre_inc_addr: assert property (
    accept && is_rd_op && instr_opcode[1:0] == 2'b11 |=>
      (s.ptr == $past(s.ptr) + 21'h000001) ##1 (pm_rd && pm_addr == $past(s.ptr[20:1])))
    else $error("pre-increment read used wrong word address");
  // Latch takes the byte lane picked by pointer bit 0
  a_latch_load: assert property (
    s.st == ST_COMPLETE && !s.is_write |=>
      s.latch == ($past(s.eff[0]) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])))
    else $error("latch not loaded with selected memory byte");
  // Read strobe and word address for modes that keep the pointer first
  a_read_addr: assert property (
    s_acc_rd_plain |=> s_rd_steps)
    else $error("read strobe or word address out of step");
  // Post-increment steps the pointer once the transfer is done
  a_post_inc_ptr: assert property (
    s.st == ST_COMPLETE && s.mode == MODE_POST_INC |=> s.ptr == $past(s.ptr) + 21'h000001)
    else $error("post-increment did not advance pointer");
  // Post-decrement steps the pointer back once the transfer is done
  a_post_dec_ptr: assert property (
    s.st == ST_COMPLETE && s.mode == MODE_POST_DEC |=> s.ptr == $past(s.ptr) - 21'h000001)
    else $error("post-decrement did not step pointer back");
  // No-change mode holds the pointer up to and through completion
  a_no_change: assert property (
    accept && instr_opcode[1:0] == 2'b00 |=> $stable(s.ptr)[*3])
    else $error("pointer moved in no-change mode");
  // Busy for two cycles, then a single done
  a_two_cycles: assert property (
    accept |=> s_done_seq)
    else $error("instruction did not complete in two cycles");
  // Done never stands two cycles in a row
  a_done_pulse: assert property (
    done |=> !done)
    else $error("done held longer than one cycle");
  // An idle cycle without a taken opcode starts nothing
  a_idle_quiet: assert property (
    s.st == ST_IDLE && !accept |=> !busy && !pm_rd)
    else $error("unit left idle without a table opcode");
  // Table writes never strobe program memory
  a_write_no_mem: assert property (
    s_acc_wr |=> !pm_rd [*3])
    else $error("table write touched program memory");
  // Table reads leave the holding registers alone
  a_read_hold: assert property (
    s_acc_rd |=> $stable(hold_data)[*3])
    else $error("table read changed a holding register");
  // Selected holding register takes the latch
  a_hold_select: assert property (
    hold_we |=> hold_data[{$past(s.eff[2:0]), 3'b000} +: 8] == $past(s.latch))
    else $error("holding register not loaded from latch");
  // Unselected holding registers keep their bytes
  for (genvar i = 0; i < HOLD_N; i++) begin : g_keep
    a_hold_keep: assert property (
      hold_we && s.eff[2:0] != 3'(i) |=>
        hold_data[8*i +: 8] == $past(hold_data[8*i +: 8]))
      else $error("unselected holding register changed");
  end
  // Pointer and latch writes are refused while an instruction runs
  a_wr_refused: assert property (
    apb_setup && pwrite && busy && (paddr == ADDR_PTR || paddr == ADDR_LATCH) |=>
      pready && pslverr)
    else $error("pointer or latch write accepted while busy");
  // Status bit 0 reports busy as seen in the setup cycle
  a_status_busy: assert property (
    apb_setup && !pwrite && paddr == ADDR_STATUS |=> prdata == {31'h00000000, $past(busy)})
    else $error("status read did not report busy");
endmodule : trw_top

// ==== pkg/trw_pkg.sv ====
// Constants and types for the table read/write unit.
// Assumes a 16-bit word program memory that answers in the cycle of its read strobe.
package trw_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned PTR_W     = 21;
  localparam int unsigned HOLD_N    = 8;
  localparam int unsigned HOLD_IW   = 3;
  // ---------------------------------------------------------------
  // Opcodes: upper 14 bits select the instruction, low 2 bits the mode
  // ---------------------------------------------------------------
  localparam logic [13:0] OP_READ   = 14'h0002;
  localparam logic [13:0] OP_WRITE  = 14'h0003;
  // ---------------------------------------------------------------
  // APB map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_PTR    = 8'h00;
  localparam logic [7:0]  ADDR_LATCH  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_HOLD   = 8'h20;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [20:0] RST_PTR   = 21'h000000;
  localparam logic [7:0]  RST_LATCH = 8'h00;
  localparam logic [7:0]  RST_HOLD  = 8'hff;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NONE     = 2'b00,
    MODE_POST_INC = 2'b01,
    MODE_POST_DEC = 2'b10,
    MODE_PRE_INC  = 2'b11
  } trw_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_ACCESS   = 2'b01,
    ST_COMPLETE = 2'b10
  } trw_st_t;
endpackage : trw_pkg

// ==== verilog/trw_hold_regs.sv ====
// Eight byte-wide holding registers that stage data for flash programming.
// Assumes the writer presents one write strobe with index and data.
`timescale 1ns/1ps
module trw_hold_regs
  import trw_pkg::*;
#(
  parameter int unsigned N = trw_pkg::HOLD_N
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           wr_en,
  input  wire logic [2:0]     wr_idx,
  input  wire logic [7:0]     wr_data,
  output logic      [N*8-1:0] hold_data
);
  import trw_pkg::*;

  typedef struct packed {
    logic [N-1:0][7:0] bytes;
  } trw_hold_t;

  trw_hold_t          s;
  trw_hold_t          next_s;
  logic [N-1:0][7:0]  next_bytes;

  // ---------------------------------------------------------------
  // Per-entry write select
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_ent
    assign next_bytes[i] = (wr_en && wr_idx == 3'(i)) ? wr_data : s.bytes[i];
  end

  // Next state
  always_comb begin
    next_s       = s;
    next_s.bytes = next_bytes;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{bytes: {N{RST_HOLD}}};
    end else begin
      s <= next_s;
    end
  end

  assign hold_data = s.bytes;
endmodule : trw_hold_regs

// ==== tb/trw_pm_model.sv ====
// Program memory model: 16-bit words, answers combinationally.
// Assumes pm_addr and pm_rd come from the unit on the same clock.
`timescale 1ns/1ps
module trw_pm_model (
  input  wire logic        pm_rd,
  input  wire logic [19:0] pm_addr,
  output logic      [15:0] pm_rdata
);
  logic [15:0] word;
  // Fixed content derived from the word address
  assign word = {pm_addr[7:0] ^ 8'ha5, pm_addr[15:8] ^ pm_addr[7:0]};
  // Unselected port shows the inverse, so stale data never looks valid
  assign pm_rdata = pm_rd ? word : ~word;
endmodule : trw_pm_model

// ==== tb/tb.sv ====
// Testbench for the table read/write unit: APB tasks and instruction calls.
// Assumes the program memory model in trw_pm_model.sv.
`timescale 1ns/1ps
module tb;
  import trw_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_opcode = 16'h0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        busy, done, pm_rd, pready, pslverr;
  logic [19:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [63:0] hold_data;
  logic [31:0] prdata;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n_rd = 0;
  // ---------------------------------------------------------------
  // Clock, design and memory
  // ---------------------------------------------------------------
  always #2.5 pclk = ~pclk;
  // Count memory read strobes
  always @(posedge pclk) if (pm_rd === 1'b1) n_rd++;
  trw_top uut (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .busy(busy), .done(done), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .hold_data(hold_data), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  trw_pm_model pm (.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e_exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk(err, e_exp);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e_exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk(err, e_exp);
  endtask : rd_chk
  // Offers one opcode and waits for done
  task automatic exec(input logic [15:0] op);
    int n;
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    @(posedge pclk);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n == 1) chk(busy, 1'b1);
    end while (done !== 1'b1 && n < 10);
    if (done !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    chk(n, 3);
  endtask : exec
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [20:0] base [5] = '{21'h1a356, 21'h1a357, 21'h0a358, 21'h01389a, 21'h1fffff};
    logic [1:0]  mode [5] = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd1};
    logic [20:0] p, e, q;
    logic [15:0] w;
    logic [7:0]  b, v;
    logic [63:0] eh;
    int          r;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    eh = {8{8'hff}};
    chk(hold_data, eh);
    rd_chk(ADDR_PTR, 32'h0, 1'b0);
    rd_chk(ADDR_LATCH, 32'h0, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    wr(ADDR_STATUS, 32'h1, 1'b1);
    wr(ADDR_HOLD, 32'h1, 1'b1);
    // Reads then writes over every mode, a wrap at the top of the range
    for (int k = 0; k < 10; k++) begin
      p = base[k % 5];
      e = (mode[k % 5] == 2'd3) ? p + 21'h1 : p;
      q = (mode[k % 5] == 2'd0) ? p : (mode[k % 5] == 2'd2) ? p - 21'h1 : p + 21'h1;
      w = {e[8:1] ^ 8'ha5, e[16:9] ^ e[8:1]};
      b = e[0] ? w[15:8] : w[7:0];
      v = 8'h30 + 8'(k);
      wr(ADDR_PTR, {11'h0, p}, 1'b0);
      if (k < 5) begin
        r = n_rd;
        exec({OP_READ, mode[k]});
        chk(n_rd, r + 1);
        rd_chk(ADDR_LATCH, {24'h0, b}, 1'b0);
      end else begin
        wr(ADDR_LATCH, {24'h0, v}, 1'b0);
        r = n_rd;
        exec({OP_WRITE, mode[k - 5]});
        chk(n_rd, r);
        eh[8 * e[2:0] +: 8] = v;
        chk(hold_data, eh);
        rd_chk(ADDR_HOLD + {3'b000, e[2:0], 2'b00}, {24'h0, v}, 1'b0);
      end
      rd_chk(ADDR_PTR, {11'h0, q}, 1'b0);
    end
    // Pointer, then latch, writes during an instruction are refused
    for (int j = 0; j < 2; j++) begin
      fork
        exec(j == 0 ? {OP_READ, 2'd0} : {OP_WRITE, 2'd0});
        begin
          @(posedge pclk);
          wr(j == 0 ? ADDR_PTR : ADDR_LATCH, 32'h123, 1'b1);
        end
      join
    end
    rd_chk(ADDR_PTR, 32'h0, 1'b0);
    rd_chk(ADDR_LATCH, 32'h0, 1'b0);
    rd_chk(ADDR_HOLD, 32'h0, 1'b0);
    // A non-table opcode starts nothing
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_opcode <= 16'h0010;
    @(posedge pclk);
    instr_valid <= 1'b0;
    repeat (3) begin
      @(posedge pclk);
      chk(busy, 1'b0);
    end
    report_and_stop();
  end
endmodule : tb
